// ===== stopwatch_defs.vh
// Constants for the two-digit decimal stopwatch: I/O addresses,
// bit positions, reset values and timing counts.
// Assumes a 50 MHz reference clock and 8-bit I/O addresses.
`ifndef STOPWATCH_DEFS_VH
`define STOPWATCH_DEFS_VH

// ===========================================================
// I/O addresses
`define ADDR_HUNDREDTHS 8'hE2
`define ADDR_TENTHS 8'hE3
`define ADDR_IRQ_ENABLE 8'hEA
`define ADDR_IRQ_FLAGS 8'hEE
`define ADDR_RUN_CONTROL 8'hF9

// ===========================================================
// Bit positions
`define BIT_CLEAR 0
`define BIT_RUN 1
`define BIT_TIMER_CLEAR 2
`define BIT_TEN_HZ 0
`define BIT_ONE_HZ 1

// ===========================================================
// Reset values
`define RESET_DIGIT 4'h0
`define RESET_NIBBLE 4'h0

// ===========================================================
// Timing
`define CLOCK_HZ 50000000
`define TICK_TIME_US 10000
`define TICK_CYCLES (`CLOCK_HZ / 1000000 * `TICK_TIME_US)
`define PRESCALE_WIDTH 20

`endif

// ===== bcd_digit.v
// One decimal counting digit with clear, advance and carry out.
// Assumes the same clock and reset as the stopwatch register block.
`timescale 1ns/1ps
`include "stopwatch_defs.vh"

module bcd_digit (
   input wire clk,
   input wire arst_n,
   input wire clear,
   input wire advance,
   output reg [3:0] value,
   output wire carry
);
   assign carry = advance && (value == 4'h9);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         value <= `RESET_DIGIT;
      end else if (clear) begin
         value <= `RESET_DIGIT;
      end else if (advance) begin
         if (value == 4'h9) begin
            value <= 4'h0;
         end else begin
            value <= value + 4'h1;
         end
      end
   end
endmodule

// ===== bcd_stopwatch_timer.v
// Two-digit decimal stopwatch with run and clear control, 10 Hz and
// 1 Hz event flags and their enables, on a 4-bit I/O memory port.
// Assumes the core's strobes are synchronous to REF_CLK.
`timescale 1ns/1ps
`include "stopwatch_defs.vh"

module bcd_stopwatch_timer #(
   parameter TICK_COUNT = `TICK_CYCLES
) (
   input wire REF_CLK,
   input wire ARST_N,
   input wire [7:0] IO_ADDR,
   input wire IO_WRITE,
   input wire IO_READ,
   input wire [3:0] IO_WDATA,
   output reg [3:0] IO_RDATA,
   output reg TIMER_CLEAR,
   output wire IRQ_ONE_HZ,
   output wire IRQ_TEN_HZ
);
   // ========================================================
   // Control registers
   reg count_run_bit;
   reg clear_pulse;
   reg one_hz_irq_enable;
   reg ten_hz_irq_enable;
   reg one_hz_event_flag;
   reg ten_hz_event_flag;
   reg [`PRESCALE_WIDTH-1:0] prescale;
   reg ten_hz_level_d;
   reg one_hz_level_d;

   wire wr_ctrl = IO_WRITE && (IO_ADDR == `ADDR_RUN_CONTROL);
   wire wr_mask = IO_WRITE && (IO_ADDR == `ADDR_IRQ_ENABLE);
   wire rd_flags = IO_READ && (IO_ADDR == `ADDR_IRQ_FLAGS);
   wire [3:0] hundredths_digit;
   wire [3:0] tenths_digit;
   wire tick;
   wire hundredths_carry;
   wire tenths_carry;

   // Prescaler is private to the stopwatch; the clock timer
   // clear only leaves the block as a pulse.
   assign tick = count_run_bit && !clear_pulse &&
      (prescale == TICK_COUNT - 1);

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         count_run_bit <= 1'b0;
         clear_pulse <= 1'b0;
         TIMER_CLEAR <= 1'b0;
         one_hz_irq_enable <= 1'b0;
         ten_hz_irq_enable <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            count_run_bit <= IO_WDATA[`BIT_RUN];
         end
         clear_pulse <= wr_ctrl && IO_WDATA[`BIT_CLEAR];
         TIMER_CLEAR <= wr_ctrl && IO_WDATA[`BIT_TIMER_CLEAR];
         if (wr_mask) begin
            one_hz_irq_enable <= IO_WDATA[`BIT_ONE_HZ];
            ten_hz_irq_enable <= IO_WDATA[`BIT_TEN_HZ];
         end
      end
   end

   // ========================================================
   // Divider and digits
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prescale <= {`PRESCALE_WIDTH{1'b0}};
      end else if (clear_pulse) begin
         prescale <= {`PRESCALE_WIDTH{1'b0}};
      end else if (count_run_bit) begin
         if (tick) begin
            prescale <= {`PRESCALE_WIDTH{1'b0}};
         end else begin
            prescale <= prescale + 1'b1;
         end
      end
   end

   bcd_digit u_hundredths (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .clear(clear_pulse),
      .advance(tick),
      .value(hundredths_digit),
      .carry(hundredths_carry)
   );

   bcd_digit u_tenths (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .clear(clear_pulse),
      .advance(hundredths_carry),
      .value(tenths_digit),
      .carry(tenths_carry)
   );

   // ========================================================
   // Event flags
   // 10 Hz is high for hundredths 0..4, 1 Hz for tenths 0..4;
   // both fall as the digit passes 4 to 5.
   wire ten_hz_level = (hundredths_digit < 4'h5);
   wire one_hz_level = (tenths_digit < 4'h5);
   wire ten_hz_fall = ten_hz_level_d && !ten_hz_level;
   wire one_hz_fall = one_hz_level_d && !one_hz_level;

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ten_hz_level_d <= 1'b1;
         one_hz_level_d <= 1'b1;
         ten_hz_event_flag <= 1'b0;
         one_hz_event_flag <= 1'b0;
      end else begin
         ten_hz_level_d <= ten_hz_level;
         one_hz_level_d <= one_hz_level;
         // A new edge beats the read clear, so no event is lost
         if (ten_hz_fall) begin
            ten_hz_event_flag <= 1'b1;
         end else if (rd_flags) begin
            ten_hz_event_flag <= 1'b0;
         end
         if (one_hz_fall) begin
            one_hz_event_flag <= 1'b1;
         end else if (rd_flags) begin
            one_hz_event_flag <= 1'b0;
         end
      end
   end

   assign IRQ_TEN_HZ = ten_hz_event_flag && ten_hz_irq_enable;
   assign IRQ_ONE_HZ = one_hz_event_flag && one_hz_irq_enable;

   // ========================================================
   // Read data, registered one cycle after the read strobe.
   // No snapshot: software must repair torn pairs.
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IO_RDATA <= `RESET_NIBBLE;
      end else if (IO_READ) begin
         case (IO_ADDR)
            `ADDR_HUNDREDTHS: IO_RDATA <= hundredths_digit;
            `ADDR_TENTHS: IO_RDATA <= tenths_digit;
            `ADDR_IRQ_ENABLE: begin
               IO_RDATA <= {2'b00, one_hz_irq_enable,
                  ten_hz_irq_enable};
            end
            `ADDR_IRQ_FLAGS: begin
               IO_RDATA <= {2'b00, one_hz_event_flag,
                  ten_hz_event_flag};
            end
            `ADDR_RUN_CONTROL: begin
               IO_RDATA <= {2'b00, count_run_bit, 1'b0};
            end
            default: IO_RDATA <= `RESET_NIBBLE;
         endcase
      end
   end
endmodule

// ===== sw_asserts.sv
// Checker on the stopwatch I/O port and its outputs.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ps
module sw_asserts (
   input wire REF_CLK,
   input wire ARST_N,
   input wire [7:0] IO_ADDR,
   input wire IO_WRITE,
   input wire IO_READ,
   input wire [3:0] IO_WDATA,
   input wire [3:0] IO_RDATA,
   input wire TIMER_CLEAR,
   input wire IRQ_ONE_HZ,
   input wire IRQ_TEN_HZ
);
   // ==============================================
   // Port relations
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_rd(a); IO_READ && IO_ADDR == a; endsequence
   sequence s_wr(a); IO_WRITE && IO_ADDR == a; endsequence
   a_unmapped_zero: assert property (
      s_rd(8'h00) |=> IO_RDATA == 4'h0) else $error("unmapped read");
   a_ctl_zero: assert property (
      s_rd(8'hF9) |=> IO_RDATA[3:2] == 2'h0 && !IO_RDATA[0])
      else $error("control read bits");
   a_flag_top: assert property (
      s_rd(8'hEE) |=> IO_RDATA[3:2] == 2'h0) else $error("flag top bits");
   a_digit_bcd: assert property (
      s_rd(8'hE2) |=> IO_RDATA <= 4'h9) else $error("digit not decimal");
   a_tclr_pulse: assert property (
      s_wr(8'hF9) ##0 IO_WDATA[2] |=> TIMER_CLEAR ##1 !TIMER_CLEAR)
      else $error("timer clear pulse");
   a_tclr_cause: assert property (
      TIMER_CLEAR |-> $past(IO_WRITE && IO_ADDR == 8'hF9 && IO_WDATA[2]))
      else $error("timer clear uncaused");
   a_enable_rdbk: assert property (
      s_wr(8'hEA) ##2 s_rd(8'hEA) |=> IO_RDATA == ($past(IO_WDATA, 3) & 4'h3))
      else $error("enable readback");
   a_rdata_hold: assert property (
      !IO_READ |=> $stable(IO_RDATA)) else $error("read data moved");
endmodule

bind bcd_stopwatch_timer sw_asserts chk_u (.REF_CLK, .ARST_N, .IO_ADDR,
   .IO_WRITE, .IO_READ, .IO_WDATA, .IO_RDATA, .TIMER_CLEAR, .IRQ_ONE_HZ,
   .IRQ_TEN_HZ);

// ===== cpu_core_model.sv
// Behavioural 4-bit core issuing one-cycle I/O strobes.
// Tasks are entered just after a falling edge and return on one.
`timescale 1ns/1ps
module cpu_core_model (
   input wire clk,
   input wire [3:0] rdata,
   output logic [7:0] addr = 8'hFF,
   output logic wr = 1'b0,
   output logic rd = 1'b0,
   output logic [3:0] wdata = 4'hF
);
   task automatic put(input logic [7:0] a, input logic [3:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      // Idle edge so the effect settles and strobes never toggle twice
      @(negedge clk);
   endtask
   task automatic get(input logic [7:0] a, output logic [3:0] d);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = rdata;
      @(negedge clk);
   endtask
   // Digits are not snapshotted, so a carry can tear the pair
   task automatic get_pair(output logic [3:0] lo, output logic [3:0] hi);
      logic [3:0] lo2;
      get(8'hE2, lo);
      get(8'hE3, hi);
      get(8'hE2, lo2);
      if (lo2 < lo) begin
         lo = lo2;
         get(8'hE3, hi);
      end
   endtask
endmodule

// ===== bcd_stopwatch_timer_tb_top.sv
// Self-checking bench for the stopwatch, short tick in simulation.
// Needs the core model and the bound checker.
`timescale 1ns/1ps
module bcd_stopwatch_timer_tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   wire [7:0] addr;
   wire wr, rd, tclr, irq1, irq10;
   wire [3:0] wdata, rdata;
   int n_mismatch = 0;
   int n_tests = 0;
   bcd_stopwatch_timer #(.TICK_COUNT(5)) dut_u (.REF_CLK(clk),
      .ARST_N(arst_n), .IO_ADDR(addr), .IO_WRITE(wr), .IO_READ(rd),
      .IO_WDATA(wdata), .IO_RDATA(rdata), .TIMER_CLEAR(tclr),
      .IRQ_ONE_HZ(irq1), .IRQ_TEN_HZ(irq10));
   cpu_core_model core_u (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
      .rd(rd), .wdata(wdata));
   // ==============================================
   // Scenarios
   task automatic chk(input string what, input logic [3:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic t_reset;
      logic [3:0] d;
      logic [7:0] a [6] = '{8'hE2, 8'hE3, 8'hEA, 8'hEE, 8'hF9, 8'h00};
      foreach (a[i]) begin
         core_u.get(a[i], d);
         chk("reset value", d, 4'h0);
      end
      $display("t_reset done");
   endtask
   task automatic t_count;
      logic [3:0] d, lo, hi, lo2, hi2;
      core_u.put(8'hF9, 4'h3);
      core_u.get(8'hF9, d);
      chk("run bit", d, 4'h2);
      repeat (60) @(negedge clk);
      core_u.put(8'hF9, 4'h0);
      core_u.get_pair(lo, hi);
      chk("tenths carry", hi, 4'h1);
      repeat (20) @(negedge clk);
      core_u.get_pair(lo2, hi2);
      chk("held hundredths", lo2, lo);
      chk("held tenths", hi2, hi);
      $display("t_count done");
   endtask
   task automatic t_clear;
      logic [3:0] lo, hi, d;
      core_u.put(8'hF9, 4'h5);
      core_u.get_pair(lo, hi);
      chk("cleared pair", {lo | hi}, 4'h0);
      core_u.get(8'hF9, d);
      chk("clear bit", d, 4'h0);
      $display("t_clear done");
   endtask
   task automatic t_flags;
      logic [3:0] d;
      core_u.put(8'hEA, 4'hF);
      core_u.get(8'hEA, d);
      chk("enable readback", d, 4'h3);
      core_u.put(8'hF9, 4'h3);
      repeat (300) @(negedge clk);
      core_u.put(8'hF9, 4'h0);
      chk("1 Hz request", {3'h0, irq1}, 4'h1);
      chk("10 Hz request", {3'h0, irq10}, 4'h1);
      core_u.get(8'hEE, d);
      chk("flags", d, 4'h3);
      chk("request after read", {2'h0, irq1, irq10}, 4'h0);
      core_u.get(8'hEE, d);
      chk("flags after read", d, 4'h0);
      core_u.put(8'hEA, 4'h0);
      // Clear first so exactly one 4 to 5 crossing of hundredths follows
      core_u.put(8'hF9, 4'h3);
      repeat (40) @(negedge clk);
      core_u.put(8'hF9, 4'h0);
      chk("masked request", {2'h0, irq1, irq10}, 4'h0);
      core_u.get(8'hEE, d);
      chk("masked flag", d, 4'h1);
      $display("t_flags done");
   endtask
   task automatic close_out;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==============================================
   // Clock, reset, sequence and watchdog
   initial begin
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      t_reset;
      t_count;
      t_clear;
      t_flags;
      close_out;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      close_out;
   end
endmodule
